// *** verilog/write_guard.sv ***
`timescale 1ns/10ps
// write-protect, latch and status-write logic of a serial eeprom
module write_guard #(
    parameter int PROG_CYCLES = wp_pkg::PROG_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic protect_n,
    output logic so,
    output logic so_oe,
    output logic write_latch_flag,
    output logic write_busy_flag,
    output logic block_guard_hi,
    output logic block_guard_lo,
    output logic array_wr_start,
    output logic [wp_pkg::ADDR_W-1:0] array_wr_addr,
    output logic array_wr_refused
);
    typedef enum logic [2:0] {S_BLOCK, S_OP, S_ADDR, S_DATA, S_STAT_WR, S_STAT_RD, S_SKIP} phase_type;

    // link domain: runs on sck; a frame's results stand while chip select is high
    logic link_reset;
    assign link_reset = reset | cs_n;
    phase_type phase_reg;
    logic [5:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [wp_pkg::ADDR_W-1:0] addr_reg;
    logic [1:0] stat_data_reg;
    logic byte_done_reg;
    logic [7:0] stat_out_reg;
    logic armed_reg;
    logic [7:0] shift_next;
    assign shift_next = {shift_reg[6:0], si};

    // cleared while deselected, so the first sck edge of a frame restarts the engine
    logic started_reg;
    phase_type phase_cur;
    logic [5:0] cnt_cur;
    assign phase_cur = started_reg ? phase_reg : S_OP;
    assign cnt_cur = started_reg ? bit_cnt_reg : wp_pkg::CNT_ZERO;
    always_ff @(posedge sck or posedge link_reset) begin
        if (link_reset)
            started_reg <= 1'b0;
        else
            started_reg <= 1'b1;
    end

    // status bits seen from the link side through two flops; the guard pair only moves between frames
    logic busy_s1_reg, busy_s2_reg, latch_s1_reg, latch_s2_reg;
    logic [1:0] guard_s1_reg, guard_s2_reg;
    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            latch_s1_reg <= 1'b0;
            latch_s2_reg <= 1'b0;
            guard_s1_reg <= wp_pkg::GUARD_RESET;
            guard_s2_reg <= wp_pkg::GUARD_RESET;
        end else begin
            busy_s1_reg <= write_busy_flag;
            busy_s2_reg <= busy_s1_reg;
            latch_s1_reg <= write_latch_flag;
            latch_s2_reg <= latch_s1_reg;
            guard_s1_reg <= {block_guard_hi, block_guard_lo};
            guard_s2_reg <= guard_s1_reg;
        end
    end

    function automatic logic opcode_is(input logic [7:0] op, input logic [2:0] code);
        return op[7:4] == wp_pkg::OP_HI_NIB && op[2:0] == code;
    endfunction

    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            phase_reg <= S_OP;
            bit_cnt_reg <= wp_pkg::CNT_ZERO;
            shift_reg <= 8'h00;
            addr_reg <= '0;
            stat_data_reg <= wp_pkg::GUARD_RESET;
            byte_done_reg <= 1'b0;
            stat_out_reg <= 8'h00;
        end else begin
            shift_reg <= shift_next;
            byte_done_reg <= 1'b0;
            phase_reg <= phase_cur;
            if (cnt_cur == 6'(wp_pkg::BYTE_BITS - 1)) begin
                bit_cnt_reg <= wp_pkg::CNT_ZERO;
                unique case (phase_cur)
                    S_OP: begin
                        byte_done_reg <= 1'b1;
                        if (opcode_is(shift_next, wp_pkg::OP_ARRAY_WR) && !busy_s2_reg) begin
                            phase_reg <= S_ADDR;
                            addr_reg[wp_pkg::ADDR_W-1] <= shift_next[3];
                        end else if (opcode_is(shift_next, wp_pkg::OP_STATUS_WR) && !busy_s2_reg)
                            phase_reg <= S_STAT_WR;
                        else if (opcode_is(shift_next, wp_pkg::OP_ARRAY_WR)
                                || opcode_is(shift_next, wp_pkg::OP_STATUS_WR))
                            phase_reg <= S_BLOCK;
                        else if (opcode_is(shift_next, wp_pkg::OP_STATUS_RD)) begin
                            phase_reg <= S_STAT_RD;
                            stat_out_reg <= {4'h0, guard_s2_reg, latch_s2_reg, busy_s2_reg};
                        end else
                            phase_reg <= S_SKIP;
                    end
                    S_ADDR: begin
                        addr_reg[wp_pkg::ADDR_LO_BITS-1:0] <= shift_next;
                        phase_reg <= S_DATA;
                    end
                    S_DATA: byte_done_reg <= 1'b1;
                    S_STAT_WR: begin
                        stat_data_reg <= {shift_next[wp_pkg::GUARD_HI_POS], shift_next[wp_pkg::GUARD_LO_POS]};
                        byte_done_reg <= 1'b1;
                        phase_reg <= S_SKIP;
                    end
                    default: ;
                endcase
            end else begin
                bit_cnt_reg <= cnt_cur + 6'h01;
                if (phase_cur == S_STAT_RD)
                    stat_out_reg <= {stat_out_reg[6:0], 1'b0};
            end
        end
    end

    // opcode of the latest frame, taken at its eighth sck edge and held after cs_n rises
    logic [7:0] last_op_reg;
    always_ff @(posedge sck or posedge reset) begin
        if (reset)
            last_op_reg <= 8'h00;
        else if (phase_cur == S_OP && cnt_cur == 6'(wp_pkg::BYTE_BITS - 1))
            last_op_reg <= shift_next;
    end

    // serial output undriven until selected and a status read runs
    assign so = stat_out_reg[7];
    assign so_oe = !cs_n && started_reg && phase_reg == S_STAT_RD && armed_reg;

    // falling chip select seen in clk, to arm the device after power-up
    logic frame_end_pulse;
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
    logic fall_seen_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end
    // every rise of chip select ends a frame; the toggle crossing carries it into clk
    cdc_event frame_end_sync (.src_clk(cs_n), .src_reset(reset), .src_pulse(1'b1),
        .dst_clk(clk), .dst_reset(reset), .dst_pulse(frame_end_pulse));

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            armed_reg <= 1'b0;
        else if (!cs_s2_reg && cs_s3_reg)
            armed_reg <= 1'b1;
    end
    assign fall_seen_reg = armed_reg;

    // sck has stopped and cs_n is high when the pulse arrives, so these link flops hold still
    logic whole_byte, is_unlock, is_lock, is_stat_wr, is_arr_wr;
    assign whole_byte = bit_cnt_reg == wp_pkg::CNT_ZERO && byte_done_reg;
    assign is_unlock = opcode_is(last_op_reg, wp_pkg::OP_UNLOCK);
    assign is_lock = opcode_is(last_op_reg, wp_pkg::OP_LOCK);
    assign is_stat_wr = opcode_is(last_op_reg, wp_pkg::OP_STATUS_WR) && phase_reg == S_SKIP;
    assign is_arr_wr = opcode_is(last_op_reg, wp_pkg::OP_ARRAY_WR) && phase_reg == S_DATA;

    function automatic logic addr_guarded(input logic [1:0] g, input logic [wp_pkg::ADDR_W-1:0] a);
        unique case (g)
            2'h0: return 1'b0;
            2'h1: return a >= wp_pkg::QUARTER_BASE;
            2'h2: return a >= wp_pkg::HALF_BASE;
            2'h3: return 1'b1;
        endcase
    endfunction

    logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_reg;
    logic prot_s1_reg, prot_s2_reg;
    logic [1:0] guard_reg;
    logic allow, arr_ok, stat_ok, frame_valid;
    assign frame_valid = frame_end_pulse && fall_seen_reg && whole_byte;
    assign allow = prot_s2_reg && write_latch_flag && !write_busy_flag;
    assign arr_ok = frame_valid && is_arr_wr && allow && !addr_guarded(guard_reg, addr_reg);
    assign stat_ok = frame_valid && is_stat_wr && allow;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prot_s1_reg <= 1'b0;
            prot_s2_reg <= 1'b0;
        end else begin
            prot_s1_reg <= protect_n;
            prot_s2_reg <= prot_s1_reg;
        end
    end

    // guard bits model nonvolatile cells: only reset or a status write clears them, reset the stand-in for power loss
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            guard_reg <= wp_pkg::GUARD_RESET;
        else if (stat_ok)
            guard_reg <= stat_data_reg;
    end
    assign block_guard_hi = guard_reg[1];
    assign block_guard_lo = guard_reg[0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            write_latch_flag <= 1'b0;
        else if (!prot_s2_reg)
            write_latch_flag <= 1'b0;
        else if (arr_ok || stat_ok)
            write_latch_flag <= 1'b0;
        else if (frame_valid && is_lock)
            write_latch_flag <= 1'b0;
        else if (frame_valid && is_unlock)
            write_latch_flag <= 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_cnt_reg <= '0;
            write_busy_flag <= 1'b0;
        end else if (arr_ok || stat_ok) begin
            prog_cnt_reg <= ($bits(prog_cnt_reg))'(PROG_CYCLES - 1);
            write_busy_flag <= 1'b1;
        end else if (prog_cnt_reg != '0)
            prog_cnt_reg <= prog_cnt_reg - 1'b1;
        else
            write_busy_flag <= 1'b0;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            array_wr_start <= 1'b0;
            array_wr_addr <= '0;
            array_wr_refused <= 1'b0;
        end else begin
            array_wr_start <= arr_ok;
            array_wr_refused <= frame_end_pulse && !(arr_ok || stat_ok)
                && (is_arr_wr || is_stat_wr || phase_reg == S_BLOCK);
            if (arr_ok)
                array_wr_addr <= addr_reg;
        end
    end

    guard_prot_a: assert property (@(posedge clk) disable iff (reset)
        array_wr_start |-> !addr_guarded({block_guard_hi, block_guard_lo}, array_wr_addr))
        else $error("guarded block written");
    latch_pin_a: assert property (@(posedge clk) disable iff (reset)
        !prot_s2_reg |=> !write_latch_flag) else $error("latch set with pin low");
    latch_clear_a: assert property (@(posedge clk) disable iff (reset)
        (arr_ok || stat_ok) |=> !write_latch_flag && write_busy_flag) else $error("latch not cleared");
    need_latch_a: assert property (@(posedge clk) disable iff (reset)
        $rose(write_busy_flag) |-> $past(write_latch_flag)) else $error("write without latch");
    busy_hold_a: assert property (@(posedge clk) disable iff (reset)
        $rose(write_busy_flag) |-> write_busy_flag [*8]) else $error("busy dropped early");
    guard_stable_a: assert property (@(posedge clk) disable iff (reset)
        !stat_ok |=> $stable(guard_reg)) else $error("guard changed without write");
    out_quiet_a: assert property (@(posedge clk) disable iff (reset)
        !armed_reg |-> !so_oe) else $error("output driven before select");
    start_frame_a: assert property (@(posedge clk) disable iff (reset)
        array_wr_start |-> $past(frame_end_pulse)) else $error("start without frame end");
    arr_write_c: cover property (@(posedge clk) disable iff (reset) arr_ok);
    stat_write_c: cover property (@(posedge clk) disable iff (reset) stat_ok);
    refused_c: cover property (@(posedge clk) disable iff (reset) array_wr_refused);
endmodule // write_guard

// *** verilog/wp_pkg.sv ***
// shared constants for the write-protect logic
package wp_pkg;
    localparam int ADDR_W = 9;
    localparam logic [3:0] OP_HI_NIB = 4'h0;
    localparam logic [2:0] OP_UNLOCK = 3'h6;
    localparam logic [2:0] OP_LOCK = 3'h4;
    localparam logic [2:0] OP_STATUS_WR = 3'h1;
    localparam logic [2:0] OP_ARRAY_WR = 3'h2;
    localparam logic [2:0] OP_ARRAY_RD = 3'h3;
    localparam logic [2:0] OP_STATUS_RD = 3'h5;
    localparam int OP_BITS = 8;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_LO_BITS = 8;
    localparam int GUARD_LO_POS = 2;
    localparam int GUARD_HI_POS = 3;
    localparam int LATCH_POS = 1;
    localparam int BUSY_POS = 0;
    localparam logic [1:0] GUARD_RESET = 2'h0;
    localparam logic [8:0] QUARTER_BASE = 9'h180;
    localparam logic [8:0] HALF_BASE = 9'h100;
    localparam int PROG_TIME_US = 5000;
    localparam int CLK_MHZ = 125;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam logic [5:0] CNT_ZERO = 6'h00;
endpackage

// *** verilog/cdc_event.sv ***
`timescale 1ns/10ps
// toggle-based event crossing into the destination clock
module cdc_event (
    input wire logic src_clk,
    input wire logic src_reset,
    input wire logic src_pulse,
    input wire logic dst_clk,
    input wire logic dst_reset,
    output logic dst_pulse
);
    logic toggle_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;

    always_ff @(posedge src_clk or posedge src_reset) begin
        if (src_reset)
            toggle_reg <= 1'b0;
        else if (src_pulse)
            toggle_reg <= ~toggle_reg;
    end

    always_ff @(posedge dst_clk or posedge dst_reset) begin
        if (dst_reset) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= toggle_reg;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign dst_pulse = sync2_reg ^ sync3_reg;
endmodule // cdc_event

// *** tb/spi_host.sv ***
`timescale 1ns/10ps
// behavioural spi host that frames commands for the write-protect block
module spi_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    localparam time HALF = 40ns;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // msb first, mode 0; sck stands low outside frames; cut >= 0 ends the frame once bit cut is sent
    task automatic frame(input logic [31:0] bits, input int n, input int cut, output logic [7:0] rx);
        rx = 8'h00;
        #3;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = bits[i];
            #HALF sck = 1'b1;
            rx = {rx[6:0], so};
            #HALF sck = 1'b0;
            if (i == cut) break;
        end
        #HALF cs_n = 1'b1;
        // released line must not keep showing the last bit
        si = ~si;
        #200;
    endtask
endmodule // spi_host

// *** tb/testbench.sv ***
`timescale 1ns/10ps
// self-checking bench for the write-protect block
module testbench;
    localparam int PROG = 2000;
    logic clk, reset, sck, cs_n, si, protect_n, so, so_oe;
    logic write_latch_flag, write_busy_flag, block_guard_hi, block_guard_lo;
    logic array_wr_start, array_wr_refused;
    logic [wp_pkg::ADDR_W-1:0] array_wr_addr, start_addr;
    logic [7:0] rx;
    int n_mismatch = 0;
    int check_count = 0;
    int n_start = 0;
    int n_refused = 0;
    logic [1:0] tg [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    logic [8:0] ta [6] = '{9'h17F, 9'h180, 9'h0FF, 9'h100, 9'h000, 9'h1FF};
    logic tok [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

    write_guard #(.PROG_CYCLES(PROG)) write_guard_inst (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n),
        .si(si), .protect_n(protect_n), .so(so), .so_oe(so_oe), .write_latch_flag(write_latch_flag),
        .write_busy_flag(write_busy_flag), .block_guard_hi(block_guard_hi), .block_guard_lo(block_guard_lo),
        .array_wr_start(array_wr_start), .array_wr_addr(array_wr_addr), .array_wr_refused(array_wr_refused));
    spi_host spi_host_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // pulses stand one cycle, so they are caught here
    always @(posedge clk) begin
        if (array_wr_start === 1'b1) begin
            n_start++;
            start_addr = array_wr_addr;
        end
        if (array_wr_refused === 1'b1) n_refused++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op);
        spi_host_inst.frame({24'h0, op}, 8, -1, rx);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (write_busy_flag !== 1'b0 && k < PROG + 100) begin
            @(negedge clk);
            k++;
        end
        check("busy cleared", write_busy_flag, 1'b0);
    endtask

    // the rest of the data byte is all ones, only the guard pair may land
    task automatic set_guard(input logic [1:0] g);
        wait_idle();
        cmd(8'h06);
        spi_host_inst.frame({16'h0, 8'h01, 4'hF, g, 2'h3}, 16, -1, rx);
        check("guard", {block_guard_hi, block_guard_lo}, g);
        check("latch after status write", write_latch_flag, 1'b0);
        wait_idle();
    endtask

    task automatic try_write(input logic [8:0] addr, input logic ok, input logic unlock, input int cut);
        int s0;
        int r0;
        s0 = n_start;
        r0 = n_refused;
        if (unlock) cmd(8'h06);
        spi_host_inst.frame({8'h0, 4'h0, addr[8], 3'h2, addr[7:0], 8'hA5}, 24, cut, rx);
        check("write started", n_start - s0, ok);
        check("write refused", n_refused - r0, !ok);
        if (ok) check("start address", start_addr, addr);
        check("latch after write", write_latch_flag, ok ? 1'b0 : (unlock & protect_n));
    endtask

    initial begin
        reset = 1'b1;
        protect_n = 1'b1;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        check("latch at power-up", write_latch_flag, 1'b0);
        check("so enable idle", so_oe, 1'b0);
        check("busy idle", write_busy_flag, 1'b0);
        try_write(9'h000, 1'b0, 1'b0, -1);
        cmd(8'h16);
        check("latch bad nibble", write_latch_flag, 1'b0);
        cmd(8'h0E);
        check("latch unlock x", write_latch_flag, 1'b1);
        cmd(8'h0C);
        check("latch lock x", write_latch_flag, 1'b0);
        cmd(8'h06);
        @(negedge clk);
        protect_n = 1'b0;
        repeat (8) @(negedge clk);
        check("latch pin low", write_latch_flag, 1'b0);
        try_write(9'h000, 1'b0, 1'b1, -1);
        protect_n = 1'b1;
        repeat (8) @(negedge clk);
        for (int i = 0; i < 6; i++) begin
            set_guard(tg[i]);
            try_write(ta[i], tok[i], 1'b1, -1);
        end
        // last write is still programming here
        check("busy after write", write_busy_flag, 1'b1);
        spi_host_inst.frame({16'h0, 8'h05, 8'h00}, 16, -1, rx);
        check("status during busy", rx, 8'h01);
        try_write(9'h010, 1'b0, 1'b1, -1);
        check("busy kept", write_busy_flag, 1'b1);
        wait_idle();
        try_write(9'h020, 1'b0, 1'b1, 3);
        check("guard kept", {block_guard_hi, block_guard_lo}, 2'h0);
        results();
    end

    initial begin
        #600us;
        n_mismatch++;
        results();
    end
endmodule // testbench
